// ==== core/sigl_pkg.sv ====
// constants and types for the signalling link sublayer state logic
package sigl_pkg;

   // fixed link parameters, no negotiation
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned T200_MS = 1000;
   localparam int unsigned T203_MS = 10000;
   localparam int unsigned N200 = 3;
   localparam int unsigned K_WINDOW = 7;
   localparam int unsigned SEQ_MOD = 128;
   localparam int unsigned T200_CYC = (CLK_HZ / 1000) * T200_MS;
   localparam int unsigned T203_CYC = (CLK_HZ / 1000) * T203_MS;
   localparam int unsigned TMR_W = 32;
   localparam int unsigned RC_W = 8;

   // frame repertoire seen at the frame interface
   typedef enum logic [2:0] {
      FR_SABME = 3'h0,
      FR_UA = 3'h1,
      FR_DM = 3'h2,
      FR_RR = 3'h3,
      FR_RNR = 3'h4,
      FR_REJ = 3'h5,
      FR_I = 3'h6,
      FR_OTHER = 3'h7
   } frame_e;

   // basic states, gray along idle, awaiting, established, recovery
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_AWAIT = 2'h1,
      ST_EST = 2'h3,
      ST_RECOV = 2'h2
   } link_state_e;

   // printed state numbers
   localparam logic [3:0] NUM_IDLE = 4'h9;
   localparam logic [3:0] NUM_AWAIT = 4'h5;
   localparam logic [3:0] NUM_EST = 4'h7;
   localparam logic [3:0] NUM_RECOV = 4'h8;

endpackage : sigl_pkg

// ==== core/signalling_link_sublayer.sv ====
// establishment, release and supervision state logic of the signalling link sublayer
// Operation
// - only acknowledged multiple-frame transfer; no unacknowledged or management transfer
// - frames limited to SABME, UA, DM, RR, RNR, REJ, I; never DISC or FRMR
// - no address assignment states; single idle state number 9, link not established
// - no parameter negotiation; fixed system parameter values used
// - sequence numbers are modulo 128
// - establish request from management starts link establishment
// - during establishment ignore every received frame that is not unnumbered
// - initiate: send SABME, clear exceptions, reset retry counter, start T200
// - every SABME carries poll bit one
// - management establish discards pending data requests and queued I frames
// - accepting SABME: UA with F=P, zero variables, establish indication, start T203
// - refusing SABME: answer DM with F equal to received P
// - UA F=1 while waiting: stop T200, start T203, zero variables, confirm
// - DM F=1 while waiting: release indication, stop T200, idle; DM F=0 ignored
// - T200 expiry while waiting: resend SABME, restart T200, count retry
// - after N200 resends: discard, release and error indications, go idle
// - SABME while established runs re-establishment
// - layer-1 failure: discard queues, release indication, stop T200 and T203
// - idle: SABME goes to acceptance; DM F=0 starts establishment if able
// - idle: unsolicited UA raises error indication; other frames discarded
// - crossed SABMEs: send UA at once, establish on peer UA, confirm
// - DM F=0 colliding with our SABME is ignored
// - T200 is 1 s, T203 is 10 s, N200 is 3
// - at most 7 I frames outstanding unacknowledged
`timescale 1ns/10ps
`default_nettype none

module signalling_link_sublayer
   import sigl_pkg::*;
#(
   parameter int unsigned T200_CYCLES = T200_CYC,
   parameter int unsigned T203_CYCLES = T203_CYC,
   parameter int unsigned N200_MAX = N200,
   parameter int unsigned K_MAX = K_WINDOW
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic est_req_i,
   input wire logic l1_fail_i,
   input wire logic can_establish_i,
   input wire logic rx_valid_i,
   input wire frame_e rx_type_i,
   input wire logic rx_pf_i,
   input wire logic rx_cmd_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output frame_e tx_type_o,
   output logic tx_pf_o,
   output logic tx_cmd_o,
   output logic est_ind_o,
   output logic est_conf_o,
   output logic rel_ind_o,
   output logic err_ind_o,
   output logic discard_o,
   output logic seq_zero_o,
   output logic peer_busy_o,
   output logic [3:0] state_num_o,
   output logic [2:0] window_o
);

   typedef struct packed {
      link_state_e st;
      logic [3:0] num;
      logic peer_busy;
      logic [RC_W-1:0] rc;
      logic t200_run;
      logic [TMR_W-1:0] t200;
      logic t203_run;
      logic [TMR_W-1:0] t203;
      logic resp_pend;
      frame_e resp_type;
      logic resp_f;
      logic cmd_pend;
      frame_e cmd_type;
      logic tx_valid;
      frame_e tx_type;
      logic tx_pf;
      logic tx_cmd;
      logic est_ind;
      logic est_conf;
      logic rel_ind;
      logic err_ind;
      logic discard;
      logic seq_zero;
   } link_s;

   link_s r;
   link_s next_r;

   // start of our own establishment: SABME with P=1, fresh counter and T200
   function automatic link_s start_est(input link_s s);
      link_s o;
      o = s;
      o.cmd_pend = 1'b1;
      o.cmd_type = FR_SABME;
      o.peer_busy = 1'b0;
      o.rc = '0;
      o.t200_run = 1'b1;
      o.t200 = TMR_W'(T200_CYCLES);
      o.t203_run = 1'b0;
      o.st = ST_AWAIT;
      return o;
   endfunction : start_est

   // received SABME outside the waiting state: accept or refuse
   function automatic link_s take_sabme(input link_s s, input logic p, input logic ok);
      link_s o;
      o = s;
      o.resp_pend = 1'b1;
      o.resp_f = p;
      if (ok) begin
         o.resp_type = FR_UA;
         o.seq_zero = 1'b1;
         o.st = ST_EST;
         o.est_ind = 1'b1;
         o.peer_busy = 1'b0;
         o.rc = '0;
         o.t200_run = 1'b0;
         o.t203_run = 1'b1;
         o.t203 = TMR_W'(T203_CYCLES);
      end else begin
         o.resp_type = FR_DM;
      end
      return o;
   endfunction : take_sabme

   // drop back to the idle state with a release indication
   function automatic link_s go_idle(input link_s s);
      link_s o;
      o = s;
      o.st = ST_IDLE;
      o.rel_ind = 1'b1;
      o.t200_run = 1'b0;
      o.t203_run = 1'b0;
      o.cmd_pend = 1'b0;
      return o;
   endfunction : go_idle

   logic t200_exp;
   logic t203_exp;
   logic unnum;
   logic sup;

   // timer expiry and frame class decode
   always_comb begin
      t200_exp = r.t200_run && (r.t200 == '0);
      t203_exp = r.t203_run && (r.t203 == '0);
      unnum = (rx_type_i == FR_SABME) || (rx_type_i == FR_UA) || (rx_type_i == FR_DM);
      sup = (rx_type_i == FR_RR) || (rx_type_i == FR_RNR) || (rx_type_i == FR_REJ);
   end

   // next state of the whole sublayer
   always_comb begin
      next_r = r;
      next_r.est_ind = 1'b0;
      next_r.est_conf = 1'b0;
      next_r.rel_ind = 1'b0;
      next_r.err_ind = 1'b0;
      next_r.discard = 1'b0;
      next_r.seq_zero = 1'b0;
      if (r.t200_run && r.t200 != '0) begin
         next_r.t200 = r.t200 - 1'b1;
      end
      if (r.t203_run && r.t203 != '0) begin
         next_r.t203 = r.t203 - 1'b1;
      end
      if (l1_fail_i) begin
         // persistent line failure overrides everything else
         next_r = go_idle(next_r);
         next_r.discard = 1'b1;
      end else if (est_req_i) begin
         next_r = start_est(next_r);
         next_r.discard = 1'b1;
      end else begin
         unique case (r.st)
            ST_IDLE: begin
               if (rx_valid_i && rx_type_i == FR_SABME) begin
                  next_r = take_sabme(next_r, rx_pf_i, can_establish_i);
               end else if (rx_valid_i && rx_type_i == FR_DM && !rx_pf_i) begin
                  if (can_establish_i) begin
                     next_r = start_est(next_r);
                  end
               end else if (rx_valid_i && rx_type_i == FR_UA) begin
                  next_r.err_ind = 1'b1;
               end
            end
            ST_AWAIT: begin
               // only unnumbered frames matter while waiting
               if (rx_valid_i && unnum) begin
                  if (rx_type_i == FR_SABME) begin
                     // crossed SABMEs: answer now, wait for peer UA
                     next_r.resp_pend = 1'b1;
                     next_r.resp_type = FR_UA;
                     next_r.resp_f = rx_pf_i;
                  end else if (rx_type_i == FR_UA && rx_pf_i) begin
                     next_r.t200_run = 1'b0;
                     next_r.t203_run = 1'b1;
                     next_r.t203 = TMR_W'(T203_CYCLES);
                     next_r.seq_zero = 1'b1;
                     next_r.st = ST_EST;
                     next_r.est_conf = 1'b1;
                  end else if (rx_type_i == FR_DM && rx_pf_i) begin
                     next_r = go_idle(next_r);
                  end
                  // DM with F=0 falls through untouched
               end else if (t200_exp) begin
                  if (r.rc >= RC_W'(N200_MAX)) begin
                     next_r = go_idle(next_r);
                     next_r.err_ind = 1'b1;
                     next_r.discard = 1'b1;
                  end else begin
                     next_r.cmd_pend = 1'b1;
                     next_r.cmd_type = FR_SABME;
                     next_r.t200 = TMR_W'(T200_CYCLES);
                     next_r.rc = r.rc + 1'b1;
                  end
               end
            end
            ST_EST, ST_RECOV: begin
               if (rx_valid_i) begin
                  next_r.t203 = TMR_W'(T203_CYCLES);
               end
               if (rx_valid_i && rx_type_i == FR_SABME) begin
                  // peer-initiated re-establishment
                  next_r = take_sabme(next_r, rx_pf_i, can_establish_i);
                  next_r.err_ind = 1'b1;
                  next_r.discard = can_establish_i;
                  if (!can_establish_i) begin
                     next_r = go_idle(next_r);
                  end
               end else if (rx_valid_i && rx_type_i == FR_DM && !rx_pf_i) begin
                  next_r = start_est(next_r);
                  next_r.err_ind = 1'b1;
               end else if (rx_valid_i && sup) begin
                  next_r.peer_busy = (rx_type_i == FR_RNR);
                  if (r.st == ST_RECOV && rx_pf_i && !rx_cmd_i) begin
                     // poll answered: supervision is back to normal
                     next_r.st = ST_EST;
                     next_r.t200_run = 1'b0;
                     next_r.t203_run = 1'b1;
                  end
               end else if (r.st == ST_EST && t203_exp) begin
                  // idle link: poll the peer under T200 protection
                  next_r.cmd_pend = 1'b1;
                  next_r.cmd_type = FR_RR;
                  next_r.rc = '0;
                  next_r.t200_run = 1'b1;
                  next_r.t200 = TMR_W'(T200_CYCLES);
                  next_r.st = ST_RECOV;
               end else if (r.st == ST_RECOV && t200_exp) begin
                  if (r.rc >= RC_W'(N200_MAX)) begin
                     next_r = start_est(next_r);
                     next_r.err_ind = 1'b1;
                  end else begin
                     next_r.cmd_pend = 1'b1;
                     next_r.cmd_type = FR_RR;
                     next_r.t200 = TMR_W'(T200_CYCLES);
                     next_r.rc = r.rc + 1'b1;
                  end
               end
            end
         endcase
      end
      // transmit slot: responses first so a crossing UA goes out early
      if (!r.tx_valid || tx_ready_i) begin
         next_r.tx_valid = 1'b0;
         if (next_r.resp_pend) begin
            next_r.tx_valid = 1'b1;
            next_r.tx_type = next_r.resp_type;
            next_r.tx_pf = next_r.resp_f;
            next_r.tx_cmd = 1'b0;
            next_r.resp_pend = 1'b0;
         end else if (next_r.cmd_pend) begin
            next_r.tx_valid = 1'b1;
            next_r.tx_type = next_r.cmd_type;
            next_r.tx_pf = 1'b1;
            next_r.tx_cmd = 1'b1;
            next_r.cmd_pend = 1'b0;
         end
      end
      unique case (next_r.st)
         ST_IDLE: next_r.num = NUM_IDLE;
         ST_AWAIT: next_r.num = NUM_AWAIT;
         ST_EST: next_r.num = NUM_EST;
         ST_RECOV: next_r.num = NUM_RECOV;
      endcase
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{st: ST_IDLE, num: NUM_IDLE, resp_type: FR_UA, cmd_type: FR_SABME,
                tx_type: FR_SABME, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register, except window_o which is tied to K_MAX
   assign tx_valid_o = r.tx_valid;
   assign tx_type_o = r.tx_type;
   assign tx_pf_o = r.tx_pf;
   assign tx_cmd_o = r.tx_cmd;
   assign est_ind_o = r.est_ind;
   assign est_conf_o = r.est_conf;
   assign rel_ind_o = r.rel_ind;
   assign err_ind_o = r.err_ind;
   assign discard_o = r.discard;
   assign seq_zero_o = r.seq_zero;
   assign peer_busy_o = r.peer_busy;
   assign state_num_o = r.num;
   assign window_o = 3'(K_MAX);

endmodule : signalling_link_sublayer

`default_nettype wire

// ==== testbench/peer_model.sv ====
// far-end peer data link entity model
`timescale 1ns/10ps
`default_nettype none
module peer_model
   import sigl_pkg::*;
(
   input wire logic clk_i,
   input wire logic tx_valid_i,
   input wire frame_e tx_type_i,
   input wire logic tx_pf_i,
   input wire logic [1:0] mode_i,
   input wire logic slow_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output frame_e rx_type_o,
   output logic rx_pf_o,
   output logic rx_cmd_o
);
   logic inj, inj_pf, inj_cmd;
   frame_e inj_type;
   // quiet line at time zero
   initial begin
      {tx_ready_o, rx_valid_o, rx_pf_o, rx_cmd_o, inj} = 5'h00;
      rx_type_o = FR_SABME;
   end
   // bench frame is queued after a rising edge and goes out at the falling one
   task automatic send(input frame_e t, input logic p, input logic c);
      @(posedge clk_i);
      inj_type = t;
      inj_pf = p;
      inj_cmd = c;
      inj = 1'b1;
      @(negedge clk_i);
   endtask : send
   // one frame a cycle; idle descriptor lines flip so stale values never match
   always @(negedge clk_i) begin
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
      rx_valid_o <= 1'b0;
      rx_type_o <= frame_e'(~rx_type_o);
      rx_pf_o <= !rx_pf_o;
      rx_cmd_o <= !rx_cmd_o;
      if (inj) begin
         rx_valid_o <= 1'b1;
         rx_type_o <= inj_type;
         rx_pf_o <= inj_pf;
         rx_cmd_o <= inj_cmd;
         inj <= 1'b0;
      end else if (tx_valid_i && tx_ready_o && tx_type_i == FR_SABME && mode_i != 2'h0) begin
         rx_valid_o <= 1'b1;
         rx_type_o <= (mode_i == 2'h1) ? FR_UA : FR_DM;
         rx_pf_o <= tx_pf_i;
         rx_cmd_o <= 1'b0;
      end
   end
endmodule : peer_model
`default_nettype wire

// ==== testbench/sigl_sva.sv ====
// port assertions for the signalling link sublayer
`timescale 1ns/10ps
`default_nettype none
module sigl_sva
   import sigl_pkg::*;
#(
   parameter int unsigned T200_CYCLES = 20,
   parameter int unsigned N200_MAX = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic est_req_i,
   input wire logic l1_fail_i,
   input wire logic can_establish_i,
   input wire logic rx_valid_i,
   input wire frame_e rx_type_i,
   input wire logic rx_pf_i,
   input wire logic tx_valid_o,
   input wire frame_e tx_type_o,
   input wire logic tx_pf_o,
   input wire logic tx_cmd_o,
   input wire logic est_ind_o,
   input wire logic est_conf_o,
   input wire logic rel_ind_o,
   input wire logic err_ind_o,
   input wire logic discard_o,
   input wire logic seq_zero_o,
   input wire logic [3:0] state_num_o
);
   logic ok;
   logic [15:0] wait_cnt;
   // a frame arrives with no management event beside it
   assign ok = rx_valid_i && !est_req_i && !l1_fail_i;
   // length of the current wait for an answer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_cnt <= 16'h0000;
      end else begin
         wait_cnt <= (state_num_o == 4'h5) ? wait_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_req_starts_wait: assert property (est_req_i && !l1_fail_i |=> state_num_o == 4'h5 && discard_o)
      else $error("establish request not acted on");
   chk_sabme_poll_set: assert property (tx_valid_o && tx_type_o == FR_SABME |-> tx_pf_o && tx_cmd_o)
      else $error("mode setting command without poll");
   chk_no_other_frame: assert property (tx_valid_o |-> tx_type_o != FR_OTHER)
      else $error("frame outside the repertoire sent");
   chk_ua_confirms: assert property (ok && state_num_o == 4'h5 && rx_type_i == FR_UA && rx_pf_i
      |=> est_conf_o && seq_zero_o && state_num_o == 4'h7)
      else $error("final UA did not establish");
   chk_dm_releases: assert property (ok && state_num_o == 4'h5 && rx_type_i == FR_DM && rx_pf_i
      |=> rel_ind_o && !est_conf_o && state_num_o == 4'h9)
      else $error("final DM did not release");
   chk_await_ignores: assert property (ok && state_num_o == 4'h5 && rx_type_i inside {FR_RR, FR_RNR, FR_REJ, FR_I}
      |=> !est_conf_o && !est_ind_o)
      else $error("numbered frame acted on while waiting");
   chk_l1_release: assert property (l1_fail_i |=> rel_ind_o && state_num_o == 4'h9)
      else $error("layer one failure not released");
   chk_idle_ua_error: assert property (ok && state_num_o == 4'h9 && rx_type_i == FR_UA
      |=> err_ind_o && !est_ind_o && state_num_o == 4'h9)
      else $error("unsolicited UA not reported");
   chk_refuse_dm: assert property (ok && state_num_o == 4'h9 && rx_type_i == FR_SABME && !can_establish_i
      |-> ##[1:8] tx_valid_o && tx_type_o == FR_DM)
      else $error("refused SABME not answered by DM");
   chk_wait_bound: assert property (32'(wait_cnt) <= (N200_MAX + 1) * (T200_CYCLES + 1) + 4)
      else $error("wait for answer outlasts all retries");
   cover property (est_conf_o);
   cover property (est_ind_o && err_ind_o);
   cover property (rel_ind_o && err_ind_o);
   cover property (state_num_o == 4'h8 ##1 state_num_o == 4'h7);
endmodule : sigl_sva
bind signalling_link_sublayer sigl_sva #(.T200_CYCLES(T200_CYCLES), .N200_MAX(N200_MAX)) u_sva (.clk_i, .rst_i,
   .est_req_i, .l1_fail_i, .can_establish_i, .rx_valid_i, .rx_type_i, .rx_pf_i, .tx_valid_o, .tx_type_o,
   .tx_pf_o, .tx_cmd_o, .est_ind_o, .est_conf_o, .rel_ind_o, .err_ind_o, .discard_o, .seq_zero_o, .state_num_o);
`default_nettype wire

// ==== testbench/test_signalling_link_sublayer.sv ====
// self-checking bench for the signalling link sublayer
`timescale 1ns/10ps
`default_nettype none
module test_signalling_link_sublayer
   import sigl_pkg::*;
;
   logic clk_i, rst_i, est_req_i, l1_fail_i, can_establish_i, tx_ready_i, rx_valid_i, rx_pf_i, rx_cmd_i;
   logic tx_valid_o, tx_pf_o, tx_cmd_o, est_ind_o, est_conf_o, rel_ind_o, err_ind_o, discard_o, seq_zero_o;
   logic peer_busy_o, slow;
   frame_e rx_type_i, tx_type_o;
   logic [3:0] state_num_o;
   logic [2:0] window_o;
   logic [1:0] mode;
   int fails, cmp_count, sabme_n;
   wire logic [5:0] ev = {seq_zero_o, discard_o, est_ind_o, est_conf_o, rel_ind_o, err_ind_o};
   wire logic [5:0] txd = {tx_valid_o, tx_type_o, tx_pf_o, tx_cmd_o};
   signalling_link_sublayer #(.T200_CYCLES(20), .T203_CYCLES(100), .N200_MAX(3)) u_dut (.clk_i, .rst_i,
      .est_req_i, .l1_fail_i, .can_establish_i, .rx_valid_i, .rx_type_i, .rx_pf_i, .rx_cmd_i, .tx_ready_i,
      .tx_valid_o, .tx_type_o, .tx_pf_o, .tx_cmd_o, .est_ind_o, .est_conf_o, .rel_ind_o, .err_ind_o,
      .discard_o, .seq_zero_o, .peer_busy_o, .state_num_o, .window_o);
   peer_model u_peer (.clk_i, .tx_valid_i(tx_valid_o), .tx_type_i(tx_type_o), .tx_pf_i(tx_pf_o), .mode_i(mode),
      .slow_i(slow), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_type_o(rx_type_i), .rx_pf_o(rx_pf_i),
      .rx_cmd_o(rx_cmd_i));
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // counts mode setting commands taken by the peer
   always @(posedge clk_i) begin
      if (tx_valid_o && tx_ready_i && tx_type_o === FR_SABME) sabme_n++;
   end
   task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask : step
   task automatic req();
      est_req_i = 1'b1;
      step(1);
      est_req_i = 1'b0;
   endtask : req
   task automatic l1();
      l1_fail_i = 1'b1;
      step(1);
      l1_fail_i = 1'b0;
      chk("release", 6'h19, {1'b0, rel_ind_o, state_num_o});
   endtask : l1
   task automatic s_initiate();
      for (int m = 1; m < 3; m++) begin
         l1();
         mode = 2'(m);
         req();
         chk("req events", 6'h10, ev);
         chk("req state", 6'h05, {2'b00, state_num_o});
         chk("req frame", 6'h23, txd);
         step(1);
         chk("answer events", (m == 1) ? 6'h24 : 6'h02, ev);
         chk("answer state", (m == 1) ? 6'h07 : 6'h09, {2'b00, state_num_o});
      end
   endtask : s_initiate
   task automatic s_await();
      l1();
      mode = 2'h0;
      req();
      u_peer.send(FR_I, 1'b1, 1'b1);
      step(1);
      chk("I in wait", 6'h05, {ev[3:0] != 4'h0, 1'b0, state_num_o});
      u_peer.send(FR_DM, 1'b0, 1'b0);
      step(1);
      chk("DM F0 in wait", 6'h05, {ev[3:0] != 4'h0, 1'b0, state_num_o});
      u_peer.send(FR_SABME, 1'b1, 1'b1);
      step(1);
      chk("crossed UA", 6'h26, txd);
      chk("crossed state", 6'h05, {2'b00, state_num_o});
      u_peer.send(FR_UA, 1'b1, 1'b0);
      step(1);
      chk("crossed confirm", 6'h24, ev);
   endtask : s_await
   task automatic s_retry();
      l1();
      slow = 1'b1;
      sabme_n = 0;
      req();
      for (int i = 0; i < 200 && rel_ind_o !== 1'b1; i++) step(1);
      chk("retry end", 6'h13, ev);
      chk("resend count", 6'(N200 + 1), 6'(sabme_n));
      chk("retry state", 6'h09, {2'b00, state_num_o});
      slow = 1'b0;
   endtask : s_retry
   task automatic s_idle();
      can_establish_i = 1'b0;
      u_peer.send(FR_SABME, 1'b1, 1'b1);
      step(1);
      chk("refuse DM", 6'h2A, txd);
      u_peer.send(FR_UA, 1'b1, 1'b0);
      step(1);
      chk("idle UA", 6'h01, ev);
      u_peer.send(FR_RR, 1'b0, 1'b0);
      step(1);
      chk("idle RR", 6'h09, {ev[3:0] != 4'h0, 1'b0, state_num_o});
      can_establish_i = 1'b1;
      u_peer.send(FR_DM, 1'b0, 1'b0);
      step(1);
      chk("DM F0 idle", 6'h23, txd);
      l1();
      u_peer.send(FR_SABME, 1'b1, 1'b1);
      step(1);
      chk("accept events", 6'h28, ev);
      chk("accept UA", 6'h26, txd);
      u_peer.send(FR_RNR, 1'b0, 1'b0);
      step(1);
      chk("peer busy", 6'h01, {5'h00, peer_busy_o});
      u_peer.send(FR_SABME, 1'b1, 1'b1);
      step(1);
      chk("reestablish", 6'h39, ev);
      chk("reest state", 6'h07, {2'b00, state_num_o});
      chk("busy cleared", 6'h00, {5'h00, peer_busy_o});
   endtask : s_idle
   // idle link: T203 runs out, a polled RR goes out, the final response ends recovery
   task automatic s_supervise();
      for (int i = 0; i < 150 && state_num_o !== 4'h8; i++) step(1);
      chk("poll state", 6'h08, {2'b00, state_num_o});
      chk("poll frame", 6'h2F, txd);
      u_peer.send(FR_RR, 1'b1, 1'b0);
      step(1);
      chk("poll answered", 6'h07, {2'b00, state_num_o});
   endtask : s_supervise
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // main sequence: reset, then each scenario
   initial begin
      {rst_i, est_req_i, l1_fail_i, can_establish_i, slow, mode} = 7'h48;
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      chk("reset state", 6'h09, {2'b00, state_num_o});
      chk("window", 6'h07, {3'b000, window_o});
      s_initiate();
      s_await();
      s_retry();
      s_idle();
      s_supervise();
      report_and_stop();
   end
   // watchdog: the scenarios need well under a thousand cycles
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule : test_signalling_link_sublayer
`default_nettype wire
